// File: ata_pm_pkg.sv
// Package of constants and types for the power and failure-prediction command block
package ata_pm_pkg;

  // ----------------------------------------------------------------------
  // Task-file port addresses
  // ----------------------------------------------------------------------
  localparam logic [9:0] ADDR_ERR_FEAT = 10'h1F1;  // Error on read, features on write
  localparam logic [9:0] ADDR_SECCNT   = 10'h1F2;  // Sector count port
  localparam logic [9:0] ADDR_SECNUM   = 10'h1F3;  // Sector number port
  localparam logic [9:0] ADDR_CYLLO    = 10'h1F4;  // Cylinder low port
  localparam logic [9:0] ADDR_CYLHI    = 10'h1F5;  // Cylinder high port
  localparam logic [9:0] ADDR_DEVHEAD  = 10'h1F6;  // Device/head port
  localparam logic [9:0] ADDR_CMD_COND = 10'h1F7;  // Command on write, condition on read

  // ----------------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_SLEEP_A  = 8'h99;  // Sleep
  localparam logic [7:0] OP_SLEEP_B  = 8'hE6;  // Sleep, alternate
  localparam logic [7:0] OP_PWRCHK_A = 8'h98;  // Power-mode query
  localparam logic [7:0] OP_PWRCHK_B = 8'hE5;  // Power-mode query, alternate
  localparam logic [7:0] OP_PREDICT  = 8'hB0;  // Failure prediction

  // ----------------------------------------------------------------------
  // Failure-prediction subcommands and keys
  // ----------------------------------------------------------------------
  localparam logic [7:0] SUB_RD_ATTR  = 8'hD0;  // Read attribute values
  localparam logic [7:0] SUB_RD_THR   = 8'hD1;  // Read thresholds
  localparam logic [7:0] SUB_AUTOSAVE = 8'hD2;  // Attribute autosave on/off
  localparam logic [7:0] SUB_SAVE     = 8'hD3;  // Save attribute values
  localparam logic [7:0] SUB_ENABLE   = 8'hD8;  // Enable prediction
  localparam logic [7:0] SUB_DISABLE  = 8'hD9;  // Disable prediction
  localparam logic [7:0] SUB_STATUS   = 8'hDA;  // Return status
  localparam logic [7:0] KEY_CYLLO    = 8'h4F;  // Key in cylinder low
  localparam logic [7:0] KEY_CYLHI    = 8'hC2;  // Key in cylinder high

  // ----------------------------------------------------------------------
  // Power-state codes and condition/error bit positions
  // ----------------------------------------------------------------------
  localparam logic [7:0] PWR_CODE_STANDBY = 8'h00;  // Standby, entering or leaving it
  localparam logic [7:0] PWR_CODE_IDLE    = 8'h80;  // Idle
  localparam logic [7:0] PWR_CODE_ACTIVE  = 8'hFF;  // Active
  localparam int COND_BSY_BIT  = 7;  // Busy
  localparam int COND_RDY_BIT  = 6;  // Device ready
  localparam int COND_ERR_BIT  = 0;  // Error
  localparam int ERR_ABORT_BIT = 2;  // Aborted command

  // Power mode reported by the drive's motor control
  typedef enum logic [1:0] {
    PM_ACTIVE   = 2'b00,
    PM_IDLE     = 2'b01,
    PM_STANDBY  = 2'b10,
    PM_SPINNING = 2'b11   // Moving into or out of standby
  } pwr_mode_e;

  // Command sequencer states
  typedef enum logic [1:0] {
    ST_READY  = 2'b00,
    ST_DECODE = 2'b01,
    ST_SUBWT  = 2'b10,
    ST_SLEEP  = 2'b11
  } cmd_state_e;

endpackage : ata_pm_pkg

// File: ata_power_predict_cmd.sv
// Command interpreter for sleep, power-mode query and failure-prediction entry
`timescale 1ns/1ps
module ata_power_predict_cmd (
  input  wire logic                  clk_sys_i,       // 50 MHz core clock
  input  wire logic                  reset_n_i,       // Hardware reset, sync, active low
  input  wire logic                  ce_i,            // Clock enable
  input  wire logic                  soft_reset_i,    // Software reset from device control
  input  wire logic [9:0]            addr_i,          // Task-file address
  input  wire logic                  wr_i,            // Write strobe
  input  wire logic                  rd_i,            // Read strobe
  input  wire logic [7:0]            wdata_i,         // Write data
  input  wire ata_pm_pkg::pwr_mode_e pwr_mode_i,      // Present power mode
  input  wire logic                  spindle_idle_i,  // Spindle has stopped
  input  wire logic                  predict_nv_i,    // Stored prediction enable
  input  wire logic                  attr_event_i,    // Attribute sample available
  input  wire logic                  sub_done_i,      // Subcommand engine finished
  output logic [7:0]                 rdata_o,         // Read data
  output logic                       rdata_oe_n_o,    // Read driver enable, low drives
  output logic                       intrq_o,         // Host interrupt
  output logic                       spindle_stop_o,  // Spin-down request
  output logic                       asleep_o,        // Sleep state
  output logic                       predict_en_o,    // Prediction enable, to store
  output logic                       attr_update_o,   // Attribute update pulse
  output logic                       sub_go_o,        // Subcommand engine start
  output logic [7:0]                 sub_code_o       // Subcommand to engine
);
  import ata_pm_pkg::*;

  // ----------------------------------------------------------------------
  // Task-file storage
  // ----------------------------------------------------------------------
  logic [7:0] features;     // Features port
  logic [7:0] sector_count; // Sector count port
  logic [7:0] sector_num;   // Sector number port
  logic [7:0] cyl_low;      // Cylinder low port
  logic [7:0] cyl_high;     // Cylinder high port
  logic [7:0] dev_head;     // Device/head port
  logic [7:0] error_reg;    // Error port
  logic       bsy;          // Busy
  logic       err;          // Error in condition port
  logic       restored;     // Enable flag loaded from store
  cmd_state_e state;        // Sequencer state
  logic [7:0] opcode;       // Latched command

  wire run     = reset_n_i && ce_i && !soft_reset_i;  // Normal operation
  wire cmd_wr  = wr_i && (addr_i == ADDR_CMD_COND);    // Command write
  // A command is taken only when idle and awake
  wire cmd_ok  = cmd_wr && !bsy && (state == ST_READY);

  // Power mode to code
  function automatic logic [7:0] pwr_code(input pwr_mode_e m);
    case (m)
      PM_ACTIVE: pwr_code = PWR_CODE_ACTIVE;
      PM_IDLE:   pwr_code = PWR_CODE_IDLE;
      default:   pwr_code = PWR_CODE_STANDBY;
    endcase
  endfunction : pwr_code

  // Subcommand known to this device
  function automatic logic sub_known(input logic [7:0] s);
    sub_known = (s == SUB_RD_ATTR) || (s == SUB_RD_THR) || (s == SUB_AUTOSAVE) ||
                (s == SUB_SAVE) || (s == SUB_ENABLE) || (s == SUB_DISABLE) ||
                (s == SUB_STATUS);
  endfunction : sub_known

  // Opcode of the sleep command
  function automatic logic is_sleep(input logic [7:0] c);
    is_sleep = (c == OP_SLEEP_A) || (c == OP_SLEEP_B);
  endfunction : is_sleep

  // Prediction entry checks
  wire keys_ok  = (cyl_low == KEY_CYLLO) && (cyl_high == KEY_CYLHI);
  wire sub_ok   = sub_known(features);
  wire gated_ok = predict_en_o || (features == SUB_ENABLE);

  // ----------------------------------------------------------------------
  // Parameter port writes
  // ----------------------------------------------------------------------
  // Plain writes land only while idle; sleep ignores the interface
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      features   <= 8'h00;
      sector_num <= 8'h00;
      cyl_low    <= 8'h00;
      cyl_high   <= 8'h00;
      dev_head   <= 8'h00;
    end else if (ce_i && wr_i && !bsy && state == ST_READY) begin
      case (addr_i)
        ADDR_ERR_FEAT: features   <= wdata_i;
        ADDR_SECNUM:   sector_num <= wdata_i;
        ADDR_CYLLO:    cyl_low    <= wdata_i;
        ADDR_CYLHI:    cyl_high   <= wdata_i;
        ADDR_DEVHEAD:  dev_head   <= wdata_i;
        default:       ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  // Busy, error, interrupt, sector count and sleep all move together here
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state          <= ST_READY;
      bsy            <= 1'b0;
      err            <= 1'b0;
      error_reg      <= 8'h00;
      intrq_o        <= 1'b0;
      opcode         <= 8'h00;
      sector_count   <= 8'h00;
      spindle_stop_o <= 1'b0;
      asleep_o       <= 1'b0;
      sub_go_o       <= 1'b0;
      sub_code_o     <= 8'h00;
    end else if (ce_i && soft_reset_i) begin
      state          <= ST_READY;
      bsy            <= 1'b0;
      err            <= 1'b0;
      error_reg      <= 8'h00;
      intrq_o        <= 1'b0;
      spindle_stop_o <= 1'b0;
      asleep_o       <= 1'b0;
      sub_go_o       <= 1'b0;
    end else if (ce_i) begin
      sub_go_o <= 1'b0;
      // Status read acknowledges the interrupt
      if (rd_i && addr_i == ADDR_CMD_COND && state != ST_SLEEP) begin
        intrq_o <= 1'b0;
      end
      case (state)
        ST_READY: begin
          if (cmd_ok) begin
            opcode  <= wdata_i;
            bsy     <= 1'b1;
            err     <= 1'b0;
            intrq_o <= 1'b0;
            state   <= ST_DECODE;
          end else if (wr_i && addr_i == ADDR_SECCNT && !bsy) begin
            sector_count <= wdata_i;
          end
        end
        ST_DECODE: begin
          bsy     <= 1'b0;
          intrq_o <= 1'b1;
          if (is_sleep(opcode)) begin
            spindle_stop_o <= 1'b1;
            asleep_o       <= 1'b1;
            state          <= ST_SLEEP;
          end else if (opcode == OP_PWRCHK_A || opcode == OP_PWRCHK_B) begin
            sector_count <= pwr_code(pwr_mode_i);
            state        <= ST_READY;
          end else if (opcode == OP_PREDICT && keys_ok && sub_ok && gated_ok) begin
            if (features == SUB_ENABLE || features == SUB_DISABLE) begin
              // flag changed under busy, finishes now
              state <= ST_READY;
            end else begin
              bsy        <= 1'b1;
              intrq_o    <= 1'b0;
              sub_go_o   <= 1'b1;
              sub_code_o <= features;
              state      <= ST_SUBWT;
            end
          end else begin
            err                      <= 1'b1;
            error_reg                <= 8'h00;
            error_reg[ERR_ABORT_BIT] <= 1'b1;
            state                    <= ST_READY;
          end
        end
        ST_SUBWT: begin
          // Engine reports completion
          if (sub_done_i) begin
            bsy     <= 1'b0;
            intrq_o <= 1'b1;
            state   <= ST_READY;
          end
        end
        ST_SLEEP: begin
          spindle_stop_o <= 1'b1;
        end
        default: state <= ST_READY;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Prediction enable, persistent across power cycles
  // ----------------------------------------------------------------------
  // Stored value is loaded on the first enabled cycle after reset
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      predict_en_o <= 1'b0;
      restored     <= 1'b0;
    end else if (ce_i && !restored) begin
      predict_en_o <= predict_nv_i;
      restored     <= 1'b1;
    end else if (run && state == ST_DECODE && opcode == OP_PREDICT && keys_ok) begin
      if (features == SUB_ENABLE) begin
        predict_en_o <= 1'b1;
      end else if (features == SUB_DISABLE && predict_en_o) begin
        predict_en_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Attribute collection
  // ----------------------------------------------------------------------
  // collect while enabled
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      attr_update_o <= 1'b0;
    end else if (ce_i) begin
      attr_update_o <= attr_event_i && predict_en_o;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Drivers released in sleep; the host sees a floating bus
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rdata_o      <= 8'h00;
      rdata_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      rdata_oe_n_o <= !(rd_i && state != ST_SLEEP && !soft_reset_i);
      if (rd_i) begin
        case (addr_i)
          ADDR_ERR_FEAT: rdata_o <= error_reg;
          ADDR_SECCNT:   rdata_o <= sector_count;
          ADDR_SECNUM:   rdata_o <= sector_num;
          ADDR_CYLLO:    rdata_o <= cyl_low;
          ADDR_CYLHI:    rdata_o <= cyl_high;
          ADDR_DEVHEAD:  rdata_o <= dev_head;
          ADDR_CMD_COND: begin
            rdata_o               <= 8'h00;
            rdata_o[COND_BSY_BIT] <= bsy;
            rdata_o[COND_RDY_BIT] <= !bsy && !asleep_o;
            rdata_o[COND_ERR_BIT] <= err;
          end
          default:       rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_cmd(logic [7:0] op);
    cmd_ok && wdata_i == op;
  endsequence
  sequence s_done_ok;
    !bsy && intrq_o && !err;
  endsequence
  sequence s_done_abort;
    !bsy && intrq_o && err && error_reg[ERR_ABORT_BIT];
  endsequence

  a_sleep_only_cmd: assert property (@(posedge clk_sys_i) disable iff (!run)
    $rose(asleep_o) |-> $past(is_sleep(opcode)) && $past(state) == ST_DECODE)
    else $error("Sleep entered without sleep command");
  a_sleep_sequence: assert property (@(posedge clk_sys_i) disable iff (!run)
    (s_cmd(OP_SLEEP_A) or s_cmd(OP_SLEEP_B)) |=> bsy ##1 (s_done_ok and spindle_stop_o))
    else $error("Sleep completion out of order");
  a_sleep_irq_early: assert property (@(posedge clk_sys_i) disable iff (!run)
    (s_cmd(OP_SLEEP_A) and ##0 !spindle_idle_i) |=> ##1 intrq_o)
    else $error("Sleep interrupt waited on spindle");
  a_sleep_quiet: assert property (@(posedge clk_sys_i) disable iff (!run)
    state == ST_SLEEP |=> rdata_oe_n_o && spindle_stop_o)
    else $error("Drivers active while asleep");
  a_sleep_holds: assert property (@(posedge clk_sys_i) disable iff (!run)
    state == ST_SLEEP |=> state == ST_SLEEP)
    else $error("Sleep left without reset");
  a_pwr_query: assert property (@(posedge clk_sys_i) disable iff (!run)
    (s_cmd(OP_PWRCHK_A) or s_cmd(OP_PWRCHK_B)) |=> bsy ##1 s_done_ok)
    else $error("Power query completion wrong");
  a_pwr_code: assert property (@(posedge clk_sys_i) disable iff (!run)
    (state == ST_DECODE && (opcode == OP_PWRCHK_A || opcode == OP_PWRCHK_B))
      |=> sector_count == pwr_code($past(pwr_mode_i)))
    else $error("Power code mismatch");
  a_sub_unknown: assert property (@(posedge clk_sys_i) disable iff (!run)
    (state == ST_DECODE && opcode == OP_PREDICT && !sub_known(features)) |=> s_done_abort)
    else $error("Unsupported subcommand not aborted");
  a_bad_keys: assert property (@(posedge clk_sys_i) disable iff (!run)
    (state == ST_DECODE && opcode == OP_PREDICT && !keys_ok) |=> s_done_abort)
    else $error("Bad keys not aborted");
  a_disabled_gate: assert property (@(posedge clk_sys_i) disable iff (!run)
    (state == ST_DECODE && opcode == OP_PREDICT && !predict_en_o && features != SUB_ENABLE)
      |=> s_done_abort)
    else $error("Disabled feature not aborted");
  a_attr_collect: assert property (@(posedge clk_sys_i) disable iff (!run)
    (attr_event_i && predict_en_o) |=> attr_update_o)
    else $error("Attribute update missed");
  a_enable_sub: assert property (@(posedge clk_sys_i) disable iff (!run || !restored)
    (state == ST_DECODE && opcode == OP_PREDICT && keys_ok && features == SUB_ENABLE)
      |-> bsy ##1 (s_done_ok and predict_en_o))
    else $error("Enable subcommand failed");
  a_abort_post: assert property (@(posedge clk_sys_i) disable iff (!run)
    $rose(err) |-> error_reg[ERR_ABORT_BIT] && !bsy && intrq_o)
    else $error("Abort posted incompletely");

endmodule : ata_power_predict_cmd

// File: ata_host_model.sv
// Host-side task-file driver model for the power and prediction command block
`timescale 1ns/1ps
module ata_host_model
  import ata_pm_pkg::*;
(
  input  wire logic       clk_i,    // Core clock
  output logic [9:0]      addr_o,   // Task-file address
  output logic            wr_o,     // Write strobe
  output logic            rd_o,     // Read strobe
  output logic [7:0]      wdata_o,  // Write data
  input  wire logic [7:0] rdata_i,  // Read data from device
  input  wire logic       oe_n_i    // Device read driver, low drives
);
  // ------------------------------------------------------------
  // Idle bus levels
  // ------------------------------------------------------------
  initial begin
    addr_o  = ADDR_CMD_COND;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // One write, strobe held up to its sampling edge
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // Released data flips, so a stale byte never looks valid
    wdata_o <= ~d;
  endtask : wr_reg

  // One read, data taken in the cycle after the strobe
  task automatic rd_reg(input logic [9:0] a, output logic [7:0] d, output logic oe_n);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    #1;
    // Released driver: host sees the inverse, never a stale good byte
    d    = oe_n_i ? ~rdata_i : rdata_i;
    oe_n = oe_n_i;
  endtask : rd_reg

  task automatic smart(input logic [7:0] sub, input logic [7:0] lo, input logic [7:0] hi);
    wr_reg(ADDR_CYLLO, lo);
    wr_reg(ADDR_CYLHI, hi);
    wr_reg(ADDR_ERR_FEAT, sub);
  endtask : smart
endmodule : ata_host_model

// File: tb_ata_power_and_failure_predict_cmd.sv
// Self-checking testbench for the power and prediction command block
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb_ata_power_and_failure_predict_cmd;
  import ata_pm_pkg::*;
  logic       clk_sys_i = 0, reset_n_i = 0, soft_reset_i = 0, spindle_idle_i = 0;
  logic       predict_nv_i = 0, attr_event_i = 0, sub_done_i = 0;
  pwr_mode_e  pwr_mode_i = PM_ACTIVE;
  logic [9:0] addr;                     // Host address
  logic       wr, rd, rdata_oe_n_o, intrq_o, spindle_stop_o, asleep_o;
  logic       predict_en_o, attr_update_o, sub_go_o;
  logic [7:0] wdata, rdata_o, sub_code_o, d, r;
  logic       oe;
  int         errors = 0, check_count = 0, cycles = 0, seed = 49293;
  bit         m_en = 0;                 // Model of the prediction enable
  logic [7:0] exp_q[$];                 // Expected power codes
  logic [7:0] subs[6] = '{SUB_RD_ATTR, SUB_RD_THR, SUB_AUTOSAVE, SUB_SAVE, SUB_STATUS, SUB_ENABLE};

  always #10 clk_sys_i = ~clk_sys_i;

  ata_host_model host (.clk_i(clk_sys_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata),
                       .rdata_i(rdata_o), .oe_n_i(rdata_oe_n_o));

  ata_power_predict_cmd dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
    .soft_reset_i(soft_reset_i), .addr_i(addr), .wr_i(wr), .rd_i(rd), .wdata_i(wdata),
    .pwr_mode_i(pwr_mode_i), .spindle_idle_i(spindle_idle_i), .predict_nv_i(predict_nv_i),
    .attr_event_i(attr_event_i), .sub_done_i(sub_done_i), .rdata_o(rdata_o),
    .rdata_oe_n_o(rdata_oe_n_o), .intrq_o(intrq_o), .spindle_stop_o(spindle_stop_o),
    .asleep_o(asleep_o), .predict_en_o(predict_en_o), .attr_update_o(attr_update_o),
    .sub_go_o(sub_go_o), .sub_code_o(sub_code_o));

  // ------------------------------------------------------------
  // Verdict and hang guard
  // ------------------------------------------------------------
  task automatic test_done;
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Whole run needs well under this many cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  // Hardware reset, stored enable reloaded on release
  task automatic hreset(input bit nv);
    @(posedge clk_sys_i);
    reset_n_i    <= 1'b0;
    predict_nv_i <= nv;
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    m_en = nv;
    repeat (2) @(posedge clk_sys_i);
    #1 `CHK({rdata_oe_n_o, intrq_o, asleep_o, predict_en_o}, {3'b100, m_en})
  endtask : hreset

  // Issue one command, check completion against the model
  task automatic cmd(input logic [7:0] op, input logic [7:0] sub, input logic [7:0] lo, input logic [7:0] hi);
    bit sl, ab, disp;
    sl   = op inside {OP_SLEEP_A, OP_SLEEP_B};
    ab   = !(op inside {OP_SLEEP_A, OP_SLEEP_B, OP_PWRCHK_A, OP_PWRCHK_B, OP_PREDICT});
    disp = 0;
    if (op == OP_PREDICT) begin
      ab = (lo !== KEY_CYLLO) || (hi !== KEY_CYLHI) || (!m_en && sub !== SUB_ENABLE) ||
           !(sub inside {SUB_RD_ATTR, SUB_RD_THR, SUB_AUTOSAVE, SUB_SAVE, SUB_ENABLE, SUB_DISABLE, SUB_STATUS});
      disp = !ab && (sub inside {SUB_RD_ATTR, SUB_RD_THR, SUB_AUTOSAVE, SUB_SAVE, SUB_STATUS});
      host.smart(sub, lo, hi);
      if (!ab && sub == SUB_ENABLE) m_en = 1;
      if (!ab && sub == SUB_DISABLE) m_en = 0;
    end
    host.wr_reg(ADDR_CMD_COND, op);
    // Command taken at this edge, busy now and interrupt cleared
    #1 `CHK(intrq_o, 1'b0)
    // Engine subcommands wait a random time for done
    if (disp) begin
      @(posedge clk_sys_i);
      #1 `CHK({sub_go_o, sub_code_o}, {1'b1, sub})
      repeat ($unsigned($random(seed)) % 4) @(posedge clk_sys_i);
      @(posedge clk_sys_i);
      sub_done_i <= 1'b1;
      // Still waiting on the engine, no interrupt yet
      #1 `CHK(intrq_o, 1'b0)
      @(posedge clk_sys_i);
      sub_done_i <= 1'b0;
    end
    @(posedge clk_sys_i);
    #1 `CHK(intrq_o, 1'b1)
    `CHK(asleep_o, sl)
    `CHK(predict_en_o, m_en)
    if (!sl) begin
      host.rd_reg(ADDR_CMD_COND, d, oe);
      `CHK({oe, d[COND_BSY_BIT], d[COND_ERR_BIT], intrq_o}, {2'b00, ab, 1'b0})
      host.rd_reg(ADDR_ERR_FEAT, d, oe);
      if (ab) `CHK(d[ERR_ABORT_BIT], 1'b1)
    end
  endtask : cmd

  // Attribute sample passes only while enabled
  task automatic attr_chk;
    @(posedge clk_sys_i);
    attr_event_i <= 1'b1;
    @(posedge clk_sys_i);
    attr_event_i <= 1'b0;
    #1 `CHK(attr_update_o, m_en)
  endtask : attr_chk

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    hreset(0);
    // Every mode with both query opcodes
    for (int m = 0; m < 8; m++) begin
      @(posedge clk_sys_i);
      pwr_mode_i <= pwr_mode_e'(m / 2);
      exp_q.push_back(m / 2 == 0 ? PWR_CODE_ACTIVE : m / 2 == 1 ? PWR_CODE_IDLE : PWR_CODE_STANDBY);
      cmd(m[0] ? OP_PWRCHK_B : OP_PWRCHK_A, 8'h00, 8'h00, 8'h00);
      host.rd_reg(ADDR_SECCNT, d, oe);
      `CHK(d, exp_q.pop_front())
    end
    // Disabled gate, wrong keys, then enable
    cmd(OP_PREDICT, SUB_STATUS, KEY_CYLLO, KEY_CYLHI);
    cmd(OP_PREDICT, SUB_DISABLE, KEY_CYLLO, KEY_CYLHI);
    attr_chk();
    r = 8'($random(seed));
    cmd(OP_PREDICT, SUB_ENABLE, (r == KEY_CYLLO) ? ~r : r, KEY_CYLHI);
    cmd(OP_PREDICT, SUB_ENABLE, KEY_CYLLO, KEY_CYLLO);
    cmd(OP_PREDICT, SUB_ENABLE, KEY_CYLLO, KEY_CYLHI);
    attr_chk();
    foreach (subs[i]) begin
      cmd(OP_PREDICT, subs[i], KEY_CYLLO, KEY_CYLHI);
    end
    // Random subcommands and opcodes, never sleep
    repeat (4) begin
      cmd(OP_PREDICT, 8'($random(seed)), KEY_CYLLO, KEY_CYLHI);
      r = 8'($random(seed));
      cmd((r inside {OP_SLEEP_A, OP_SLEEP_B}) ? 8'h00 : r, 8'h00, 8'h00, 8'h00);
    end
    cmd(OP_PREDICT, SUB_DISABLE, KEY_CYLLO, KEY_CYLHI);
    // Sleep with both opcodes, soft then hard wake
    for (int i = 0; i < 2; i++) begin
      cmd(i ? OP_SLEEP_B : OP_SLEEP_A, 8'h00, 8'h00, 8'h00);
      `CHK(spindle_stop_o, 1'b1)
      host.rd_reg(ADDR_CMD_COND, d, oe);
      `CHK(oe, 1'b1)
      host.wr_reg(ADDR_CMD_COND, OP_PWRCHK_A);
      repeat (3) @(posedge clk_sys_i);
      #1 `CHK(asleep_o, 1'b1)
      if (i == 0) begin
        @(posedge clk_sys_i);
        soft_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        soft_reset_i <= 1'b0;
        @(posedge clk_sys_i);
        #1 `CHK({asleep_o, intrq_o}, 2'b00)
      end else begin
        hreset(1);
      end
      cmd(OP_PWRCHK_B, 8'h00, 8'h00, 8'h00);
    end
    test_done();
  end
endmodule : tb_ata_power_and_failure_predict_cmd
